// ==== design/afeltc_fifo.sv ====
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module afeltc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned LVL_W = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [LVL_W-1:0] o_level
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [LVL_W-1:0] cnt_d;
  logic push;
  logic pop;

  // ==================================================
  // handshakes and next level
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  always_comb begin
    cnt_d = o_level;
    if (push & ~pop) begin
      cnt_d = o_level + LVL_W'(1);
    end else if (pop & ~push) begin
      cnt_d = o_level - LVL_W'(1);
    end
    if (i_flush) begin
      cnt_d = '0;
    end
  end
  // storage
  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  // pointers, level and registered ready
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      o_level <= '0;
      o_in_ready <= 1'b0;
    end else if (i_clk_en) begin
      wr_q <= i_flush ? '0 : wr_q + PTR_W'(push);
      rd_q <= i_flush ? '0 : rd_q + PTR_W'(pop);
      o_level <= cnt_d;
      o_in_ready <= cnt_d != FULL;
    end
  end
  assign o_out_valid = o_level != '0;
  assign o_out_data = mem_q[rd_q];
endmodule
`default_nettype wire

// ==== design/afeltc_pkg.sv ====
// shared constants and types of the line timing control block
package afeltc_pkg;
  // ==================================================
  // widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 12;
  localparam int unsigned PIX_W = 6;
  localparam int unsigned SET_W = 6;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LVL_W = 5;
  // ==================================================
  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_GAIN_R = 6'h04;
  localparam logic [ADDR_W-1:0] REG_GAIN_G = 6'h08;
  localparam logic [ADDR_W-1:0] REG_GAIN_B = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_OFFS_R = 6'h10;
  localparam logic [ADDR_W-1:0] REG_OFFS_G = 6'h14;
  localparam logic [ADDR_W-1:0] REG_OFFS_B = 6'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_PIXCNT = 6'h20;
  // ==================================================
  // field positions and reset values
  localparam int unsigned CTRL_CDS_BIT = 0;
  localparam int unsigned CTRL_POL_BIT = 1;
  localparam int unsigned CTRL_ROT_BIT = 2;
  localparam int unsigned CTRL_MONO_LSB = 3;
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned STAT_LINE_BIT = 0;
  localparam int unsigned STAT_FAST_BIT = 1;
  localparam int unsigned STAT_LVL_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h01;
  localparam logic [SET_W-1:0] GAIN_RST = 6'h01;
  localparam logic [SET_W-1:0] OFFS_RST = 6'h00;
  // ==================================================
  // serial configuration frame: index then data, msb first
  localparam int unsigned SER_IDX_W = 4;
  localparam int unsigned SER_DAT_W = 8;
  localparam int unsigned SER_LEN = SER_IDX_W + SER_DAT_W;
  // ==================================================
  // timing
  localparam int unsigned MCLK_PERIOD_NS = 10;
  localparam int unsigned SAMP_MIN_MCLK = 4;
  localparam int unsigned SCNT_W = 3;
  localparam logic [SCNT_W-1:0] SCNT_MAX = 3'h7;
  localparam logic [SCNT_W-1:0] SCNT_MIN = 3'(SAMP_MIN_MCLK - 1);
  localparam int unsigned BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  localparam logic [BEAT_W-1:0] BEAT_LOW = 2'h2;
  // ==================================================
  // types
  typedef enum logic [1:0] {
    COL_R = 2'b00,
    COL_G = 2'b01,
    COL_B = 2'b10
  } afeltc_colour_t;
  typedef enum logic {
    OUT_IDLE = 1'b0,
    OUT_SEND = 1'b1
  } afeltc_out_t;
endpackage

// ==== design/afeltc_top.sv ====
// sensor front end line timing, sampling control and pixel bus
// ==================================================
// Overview of operation
// - sample period at least four master clocks
// - track while sample low, hold at rise
// - with double sampling, hold reference at fall
// - otherwise hold upper/lower reference by polarity
// - clamp inputs while strobe high, sample low
// - strobe fall loads first colour settings
// - strobe fall starts active pixels
// - strobe low drives results on pixel bus
// - strobe high releases bus, serial port active
`timescale 1ns/1ps
`default_nettype none
module afeltc_top
  import afeltc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_sample_clock,
  input wire logic i_line_start_strobe,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_latch_pin,
  input wire logic i_serial_data_pin,
  input wire logic [afeltc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [afeltc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [afeltc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_conv_valid,
  input wire logic [afeltc_pkg::RES_W-1:0] i_conv_result,
  output logic o_conv_ready,
  output logic o_track_signal,
  output logic o_hold_signal,
  output logic o_hold_reference,
  output logic o_hold_ref_upper,
  output logic o_hold_ref_lower,
  output logic o_clamp,
  output logic o_clamp_upper,
  output logic [1:0] o_input_select,
  output logic [afeltc_pkg::SET_W-1:0] o_gain,
  output logic [afeltc_pkg::SET_W-1:0] o_offset,
  output logic o_line_active,
  output logic [afeltc_pkg::PIX_W-1:0] o_pix_data,
  output logic [afeltc_pkg::PIX_W-1:0] o_pix_oe_n,
  output logic o_pix_valid
);
  import afeltc_pkg::*;

  // ==================================================
  // declarations
  logic [2:0] sc_q;
  logic [2:0] ls_q;
  logic [2:0] sk_q;
  logic [2:0] la_q;
  logic [1:0] sd_q;
  logic sc_rise;
  logic sc_fall;
  logic ls_rise;
  logic ls_fall;
  logic sk_rise;
  logic la_rise;
  logic [CTRL_W-1:0] ctrl_q;
  logic [SET_W-1:0] gain_q [3];
  logic [SET_W-1:0] offs_q [3];
  logic fast_q;
  logic [DATA_W-1:0] pixcnt_q;
  logic [SCNT_W-1:0] scnt_q;
  logic seen_q;
  logic [SER_LEN-1:0] shift_q;
  logic cfg_we;
  logic [ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_data;
  afeltc_colour_t col_q;
  afeltc_colour_t first_col;
  afeltc_out_t out_q;
  logic [BEAT_W-1:0] beat_q;
  logic [RES_W-1:0] word_q;
  logic f_valid;
  logic [RES_W-1:0] f_data;
  logic f_ready;
  logic [LVL_W-1:0] f_level;

  // ==================================================
  // functions
  // pick the colour entry of a per-colour table
  function automatic logic [SET_W-1:0] pick(
    input afeltc_colour_t c,
    input logic [SET_W-1:0] r,
    input logic [SET_W-1:0] g,
    input logic [SET_W-1:0] b
  );
    case (c)
      COL_R: pick = r;
      COL_G: pick = g;
      default: pick = b;
    endcase
  endfunction
  // next colour in rotation
  function automatic afeltc_colour_t next_col(input afeltc_colour_t c);
    case (c)
      COL_R: next_col = COL_G;
      COL_G: next_col = COL_B;
      default: next_col = COL_R;
    endcase
  endfunction
  // map a two-bit field to a colour
  function automatic afeltc_colour_t to_col(input logic [1:0] v);
    case (v)
      2'h0: to_col = COL_R;
      2'h1: to_col = COL_G;
      default: to_col = COL_B;
    endcase
  endfunction

  // ==================================================
  // pin synchronisers, edges read from second stage on
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sc_q <= '0;
      ls_q <= 3'h7;
      sk_q <= '0;
      la_q <= '0;
      sd_q <= '0;
    end else if (i_clk_en) begin
      sc_q <= {sc_q[1:0], i_sample_clock};
      ls_q <= {ls_q[1:0], i_line_start_strobe};
      sk_q <= {sk_q[1:0], i_serial_clock_pin};
      la_q <= {la_q[1:0], i_serial_latch_pin};
      sd_q <= {sd_q[0], i_serial_data_pin};
    end
  end
  assign sc_rise = sc_q[1] & ~sc_q[2];
  assign sc_fall = ~sc_q[1] & sc_q[2];
  assign ls_rise = ls_q[1] & ~ls_q[2];
  assign ls_fall = ~ls_q[1] & ls_q[2];
  assign sk_rise = sk_q[1] & ~sk_q[2];
  assign la_rise = la_q[1] & ~la_q[2];

  // ==================================================
  // serial configuration port, only while strobe high
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q <= '0;
    end else if (i_clk_en && ls_q[1] && sk_rise) begin
      shift_q <= {shift_q[SER_LEN-2:0], sd_q[1]};
    end
  end
  // one write source: bus first, serial latch otherwise
  always_comb begin
    cfg_we = i_wr;
    cfg_addr = i_addr;
    cfg_data = i_wdata;
    if (!i_wr && ls_q[1] && la_rise) begin
      cfg_we = 1'b1;
      cfg_addr = ADDR_W'({shift_q[SER_LEN-1 -: SER_IDX_W], 2'b00});
      cfg_data = DATA_W'(shift_q[SER_DAT_W-1:0]);
    end
  end

  // ==================================================
  // configuration registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < 3; i++) begin
        gain_q[i] <= GAIN_RST;
        offs_q[i] <= OFFS_RST;
      end
    end else if (i_clk_en && cfg_we) begin
      case (cfg_addr)
        REG_CTRL: ctrl_q <= cfg_data[CTRL_W-1:0];
        REG_GAIN_R: gain_q[0] <= cfg_data[SET_W-1:0];
        REG_GAIN_G: gain_q[1] <= cfg_data[SET_W-1:0];
        REG_GAIN_B: gain_q[2] <= cfg_data[SET_W-1:0];
        REG_OFFS_R: offs_q[0] <= cfg_data[SET_W-1:0];
        REG_OFFS_G: offs_q[1] <= cfg_data[SET_W-1:0];
        REG_OFFS_B: offs_q[2] <= cfg_data[SET_W-1:0];
        default: ;
      endcase
    end
  end

  // ==================================================
  // sample period check; set wins over write-one clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      scnt_q <= '0;
      seen_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (i_clk_en) begin
      if (sc_rise) begin
        scnt_q <= '0;
        seen_q <= 1'b1;
      end else if (scnt_q != SCNT_MAX) begin
        scnt_q <= scnt_q + SCNT_W'(1);
      end
      if (sc_rise && seen_q && scnt_q < SCNT_MIN) begin
        fast_q <= 1'b1;
      end else if (i_wr && i_addr == REG_STATUS && i_wdata[STAT_FAST_BIT]) begin
        fast_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // sampler controls
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_track_signal <= 1'b0;
      o_hold_signal <= 1'b0;
      o_hold_reference <= 1'b0;
      o_hold_ref_upper <= 1'b0;
      o_hold_ref_lower <= 1'b0;
      o_clamp <= 1'b0;
      o_clamp_upper <= 1'b0;
    end else if (i_clk_en) begin
      o_track_signal <= ~sc_q[1];
      o_hold_signal <= sc_rise;
      o_hold_reference <= sc_fall & ctrl_q[CTRL_CDS_BIT];
      o_hold_ref_upper <= sc_fall & ~ctrl_q[CTRL_CDS_BIT] & ctrl_q[CTRL_POL_BIT];
      o_hold_ref_lower <= sc_fall & ~ctrl_q[CTRL_CDS_BIT] & ~ctrl_q[CTRL_POL_BIT];
      o_clamp <= ls_q[1] & ~sc_q[1];
      o_clamp_upper <= ctrl_q[CTRL_POL_BIT];
    end
  end

  // ==================================================
  // line state and colour sequencing
  assign first_col = ctrl_q[CTRL_ROT_BIT] ? COL_R : to_col(ctrl_q[CTRL_MONO_LSB +: 2]);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line_active <= 1'b0;
      col_q <= COL_R;
      pixcnt_q <= '0;
    end else if (i_clk_en) begin
      if (ls_fall) begin
        o_line_active <= 1'b1;
        col_q <= first_col;
        pixcnt_q <= '0;
      end else if (ls_rise) begin
        o_line_active <= 1'b0;
      end else if (o_line_active && sc_rise) begin
        pixcnt_q <= pixcnt_q + DATA_W'(1);
        if (ctrl_q[CTRL_ROT_BIT]) begin
          col_q <= next_col(col_q);
        end
      end
    end
  end
  // mux, gain and offset follow the colour in use
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_input_select <= COL_R;
      o_gain <= GAIN_RST;
      o_offset <= OFFS_RST;
    end else if (i_clk_en) begin
      o_input_select <= col_q;
      o_gain <= pick(col_q, gain_q[0], gain_q[1], gain_q[2]);
      o_offset <= pick(col_q, offs_q[0], offs_q[1], offs_q[2]);
    end
  end

  // ==================================================
  // result buffer, flushed when the line ends
  afeltc_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH),
    .LVL_W(LVL_W)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_flush(ls_rise),
    .i_in_valid(i_conv_valid & o_line_active),
    .i_in_data(i_conv_result),
    .o_in_ready(o_conv_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_ready),
    .o_level(f_level)
  );
  assign f_ready = (out_q == OUT_IDLE) & o_line_active & ~ls_q[1];

  // ==================================================
  // pixel bus: four beats, upper part twice then lower
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      out_q <= OUT_IDLE;
      beat_q <= '0;
      word_q <= '0;
    end else if (i_clk_en) begin
      case (out_q)
        OUT_IDLE: begin
          if (f_valid && f_ready) begin
            word_q <= f_data;
            beat_q <= '0;
            out_q <= OUT_SEND;
          end
        end
        OUT_SEND: begin
          beat_q <= beat_q + BEAT_W'(1);
          if (beat_q == BEAT_LAST || ls_q[1]) begin
            out_q <= OUT_IDLE;
          end
        end
        default: out_q <= OUT_IDLE;
      endcase
    end
  end
  // bus drive and data lanes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pix_oe_n <= '1;
      o_pix_data <= '0;
      o_pix_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_pix_oe_n <= ls_q[1] ? '1 : '0;
      o_pix_valid <= (out_q == OUT_SEND) & ~ls_q[1];
      if (out_q == OUT_SEND && !ls_q[1]) begin
        o_pix_data <= beat_q < BEAT_LOW ? word_q[RES_W-1 -: PIX_W]
                                        : word_q[PIX_W-1:0];
      end else begin
        o_pix_data <= '0;
      end
    end
  end

  // ==================================================
  // register read port, data only in the next cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= '0;
      if (i_rd) begin
        case (i_addr)
          REG_CTRL: o_rdata <= DATA_W'(ctrl_q);
          REG_GAIN_R: o_rdata <= DATA_W'(gain_q[0]);
          REG_GAIN_G: o_rdata <= DATA_W'(gain_q[1]);
          REG_GAIN_B: o_rdata <= DATA_W'(gain_q[2]);
          REG_OFFS_R: o_rdata <= DATA_W'(offs_q[0]);
          REG_OFFS_G: o_rdata <= DATA_W'(offs_q[1]);
          REG_OFFS_B: o_rdata <= DATA_W'(offs_q[2]);
          REG_STATUS: begin
            o_rdata[STAT_LINE_BIT] <= o_line_active;
            o_rdata[STAT_FAST_BIT] <= fast_q;
            o_rdata[STAT_LVL_LSB +: LVL_W] <= f_level;
          end
          REG_PIXCNT: o_rdata <= pixcnt_q;
          default: o_rdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/afeltc_monitor.sv ====
// checker of sampling, clamp and pixel bus timing
`timescale 1ns/1ps
`default_nettype none
module afeltc_monitor
  import afeltc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_sample_clock,
  input wire logic i_line_start_strobe,
  input wire logic o_track_signal,
  input wire logic o_hold_signal,
  input wire logic o_hold_reference,
  input wire logic o_hold_ref_upper,
  input wire logic o_hold_ref_lower,
  input wire logic o_clamp,
  input wire logic o_clamp_upper,
  input wire logic o_line_active,
  input wire logic [afeltc_pkg::PIX_W-1:0] o_pix_data,
  input wire logic [afeltc_pkg::PIX_W-1:0] o_pix_oe_n,
  input wire logic o_pix_valid
);
  // ==================================================
  // sampling and clamp
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_hold_on_rise: assert property ($rose(i_sample_clock) |-> ##[3:5] o_hold_signal)
    else $error("no signal hold after sample rise");
  a_track_while_low: assert property ($fell(i_sample_clock) |-> ##[3:5] o_track_signal)
    else $error("no tracking after sample fall");
  a_ref_on_fall: assert property ($fell(i_sample_clock) |-> ##[3:5]
    (o_hold_reference || o_hold_ref_upper || o_hold_ref_lower))
    else $error("no reference hold after sample fall");
  a_ref_by_polarity: assert property ((o_hold_ref_upper || o_hold_ref_lower) |->
    (o_hold_ref_upper == o_clamp_upper) && !o_hold_reference)
    else $error("reference hold against polarity");
  a_clamp_when_idle: assert property ((i_line_start_strobe && !i_sample_clock)[*6] |->
    o_clamp && o_track_signal)
    else $error("no clamp with strobe high and sample low");
  // ==================================================
  // pixel bus
  a_bus_released: assert property ($rose(i_line_start_strobe) |-> ##[3:5]
    (o_pix_oe_n == 6'h3F && !o_line_active))
    else $error("bus not released after strobe rise");
  a_bus_driven: assert property ($fell(i_line_start_strobe) |-> ##[3:5]
    (o_pix_oe_n == 6'h00 && o_line_active))
    else $error("bus not driven after strobe fall");
  a_beat_count: assert property (disable iff (!i_resetn || i_line_start_strobe)
    $rose(o_pix_valid) |-> o_pix_valid[*4] ##1 !o_pix_valid)
    else $error("word not four beats");
  a_beat_pairs: assert property (disable iff (!i_resetn || i_line_start_strobe)
    $rose(o_pix_valid) |-> ##1 $stable(o_pix_data) ##2 $stable(o_pix_data))
    else $error("beat pair differs");
endmodule
bind afeltc_top afeltc_monitor afeltc_monitor_inst (.i_clk_sys, .i_resetn, .i_sample_clock,
  .i_line_start_strobe, .o_track_signal, .o_hold_signal, .o_hold_reference, .o_hold_ref_upper,
  .o_hold_ref_lower, .o_clamp, .o_clamp_upper, .o_line_active, .o_pix_data, .o_pix_oe_n,
  .o_pix_valid);
`default_nettype wire

// ==== test/afeltc_scanner.sv ====
// scanner controller model: sample clock, line strobe, serial writes
`timescale 1ns/1ps
`default_nettype none
module afeltc_scanner (
  input wire logic i_clk_sys,
  output logic o_sample_clock,
  output logic o_line_start_strobe,
  output logic o_serial_clock,
  output logic o_serial_latch,
  output logic o_serial_data
);
  int half = 2; // master clocks per sample half period
  // idle levels: strobe high between lines
  initial begin
    o_sample_clock = 1'b0;
    o_line_start_strobe = 1'b1;
    o_serial_clock = 1'b0;
    o_serial_latch = 1'b0;
    o_serial_data = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // sample periods of twice half master clocks, four at the default half of 2
  task automatic sample(input int n);
    repeat (n) begin
      o_sample_clock <= 1'b0;
      tick(half);
      o_sample_clock <= 1'b1;
      tick(half);
    end
  endtask
  // frame msb first on clock rises, then latch pulse
  task automatic ser_write(input logic [3:0] idx, input logic [7:0] dat);
    logic [11:0] f;
    f = {idx, dat};
    for (int i = 11; i >= 0; i--) begin
      o_serial_data <= f[i];
      o_serial_clock <= 1'b0;
      tick(2);
      o_serial_clock <= 1'b1;
      tick(2);
    end
    o_serial_clock <= 1'b0;
    o_serial_data <= ~f[0]; // released line shows no stale bit
    o_serial_latch <= 1'b1;
    tick(3);
    o_serial_latch <= 1'b0;
    tick(1);
  endtask
  // clamp periods, then open the line on a low sample clock
  task automatic open_line();
    sample(3);
    o_sample_clock <= 1'b0;
    tick(7);
    o_line_start_strobe <= 1'b0;
    tick(1);
  endtask
  task automatic close_line();
    o_line_start_strobe <= 1'b1;
    tick(1);
  endtask
endmodule
`default_nettype wire

// ==== test/afeltc_top_test.sv ====
// self-checking bench of the line timing control block
`timescale 1ns/1ps
`default_nettype none
module afeltc_top_test;
  import afeltc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn, i_clk_en, i_wr, i_rd, i_conv_valid;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [RES_W-1:0] i_conv_result;
  wire logic i_sample_clock, i_line_start_strobe, i_serial_clock_pin, i_serial_latch_pin;
  wire logic i_serial_data_pin;
  logic [DATA_W-1:0] o_rdata;
  logic o_conv_ready, o_track_signal, o_hold_signal, o_hold_reference, o_hold_ref_upper;
  logic o_hold_ref_lower, o_clamp, o_clamp_upper, o_line_active, o_pix_valid;
  logic [1:0] o_input_select;
  logic [SET_W-1:0] o_gain, o_offset;
  logic [PIX_W-1:0] o_pix_data, o_pix_oe_n;
  int n_mismatch = 0;
  int checked = 0;
  int n_hs = 0, n_ref = 0, n_up = 0, n_lo = 0, n_cl = 0;
  afeltc_top afeltc_top_inst (.i_clk_sys, .i_resetn, .i_clk_en, .i_sample_clock,
    .i_line_start_strobe, .i_serial_clock_pin, .i_serial_latch_pin, .i_serial_data_pin,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_conv_valid, .i_conv_result, .o_conv_ready,
    .o_track_signal, .o_hold_signal, .o_hold_reference, .o_hold_ref_upper, .o_hold_ref_lower,
    .o_clamp, .o_clamp_upper, .o_input_select, .o_gain, .o_offset, .o_line_active,
    .o_pix_data, .o_pix_oe_n, .o_pix_valid);
  afeltc_scanner afeltc_scanner_inst (.i_clk_sys, .o_sample_clock(i_sample_clock),
    .o_line_start_strobe(i_line_start_strobe), .o_serial_clock(i_serial_clock_pin),
    .o_serial_latch(i_serial_latch_pin), .o_serial_data(i_serial_data_pin));
  always #5 i_clk_sys = ~i_clk_sys;
  // tally of hold and clamp pulses
  always @(posedge i_clk_sys) begin
    n_hs += int'(o_hold_signal === 1'b1);
    n_ref += int'(o_hold_reference === 1'b1);
    n_up += int'(o_hold_ref_upper === 1'b1);
    n_lo += int'(o_hold_ref_lower === 1'b1);
    n_cl += int'(o_clamp === 1'b1);
  end
  // ==================================================
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    cmp(o_rdata, e);
    @(posedge i_clk_sys);
  endtask
  task automatic push(input logic [RES_W-1:0] w[2]);
    foreach (w[k]) begin
      i_conv_valid <= 1'b1;
      i_conv_result <= w[k];
      @(negedge i_clk_sys);
      while (o_conv_ready !== 1'b1) @(negedge i_clk_sys);
      @(posedge i_clk_sys);
    end
    i_conv_valid <= 1'b0;
  endtask
  task automatic chk_word(input logic [RES_W-1:0] w);
    int t;
    t = 0;
    @(negedge i_clk_sys);
    while (o_pix_valid !== 1'b1 && t < 20) begin
      @(negedge i_clk_sys);
      t++;
    end
    for (int k = 0; k < 4; k++) begin
      cmp({o_pix_valid, o_pix_data}, {1'b1, (k < 2) ? w[11:6] : w[5:0]});
      @(negedge i_clk_sys);
    end
    cmp(o_pix_valid, 1'b0);
  endtask
  // ==================================================
  // scenarios
  task automatic t_regs();
    cmp(o_pix_oe_n, 6'h3F);
    rd_reg(REG_CTRL, 32'h1);
    wr_reg(6'h3C, 32'hFF);
    rd_reg(6'h3C, 32'h0);
    // a write while the enable is low must not land
    i_clk_en <= 1'b0;
    wr_reg(REG_GAIN_R, 32'h2A);
    i_clk_en <= 1'b1;
    rd_reg(REG_GAIN_R, 32'h1);
  endtask
  task automatic t_serial();
    afeltc_scanner_inst.ser_write(4'h2, 8'h15);
    afeltc_scanner_inst.ser_write(4'h5, 8'h0A);
    afeltc_scanner_inst.tick(4);
    rd_reg(REG_GAIN_G, 32'h15);
    rd_reg(REG_OFFS_G, 32'h0A);
    wr_reg(REG_CTRL, 32'h09);
  endtask
  task automatic t_line();
    int b_hs, b_ref, b_cl;
    b_hs = n_hs;
    b_ref = n_ref;
    b_cl = n_cl;
    afeltc_scanner_inst.open_line();
    afeltc_scanner_inst.tick(6);
    cmp(n_cl > b_cl, 1'b1);
    cmp(o_clamp, 1'b0);
    cmp(o_line_active, 1'b1);
    cmp({o_input_select, o_gain, o_offset}, {2'h1, 6'h15, 6'h0A});
    cmp(o_pix_oe_n, 6'h00);
    fork
      afeltc_scanner_inst.sample(8);
      begin
        push('{12'hA5C, 12'h3F1});
        chk_word(12'hA5C);
        chk_word(12'h3F1);
      end
    join
    @(posedge i_clk_sys);
    cmp(n_hs > b_hs, 1'b1);
    cmp(n_ref > b_ref, 1'b1);
    afeltc_scanner_inst.ser_write(4'h2, 8'h33);
    afeltc_scanner_inst.tick(4);
    rd_reg(REG_GAIN_G, 32'h15);
    rd_reg(REG_PIXCNT, 32'h8);
    rd_reg(REG_STATUS, 32'h1);
    afeltc_scanner_inst.close_line();
    afeltc_scanner_inst.tick(6);
    cmp({o_pix_oe_n, o_line_active}, {6'h3F, 1'b0});
  endtask
  // rotating colours: line opens on red, next sample moves to green
  task automatic t_rot();
    wr_reg(REG_CTRL, 32'h05);
    afeltc_scanner_inst.open_line();
    afeltc_scanner_inst.tick(6);
    cmp({o_input_select, o_gain}, {2'h0, 6'h01});
    afeltc_scanner_inst.sample(1);
    afeltc_scanner_inst.tick(4);
    cmp({o_input_select, o_gain}, {2'h1, 6'h15});
    afeltc_scanner_inst.close_line();
    afeltc_scanner_inst.tick(6);
  endtask
  // deliberately short sample periods set the sticky flag
  task automatic t_fast();
    afeltc_scanner_inst.half = 1;
    afeltc_scanner_inst.sample(3);
    afeltc_scanner_inst.half = 2;
    afeltc_scanner_inst.tick(4);
    rd_reg(REG_STATUS, 32'h2);
    wr_reg(REG_STATUS, 32'h2);
    rd_reg(REG_STATUS, 32'h0);
  endtask
  task automatic t_pol(input logic [DATA_W-1:0] ctrl);
    int b_up, b_lo;
    b_up = n_up;
    b_lo = n_lo;
    wr_reg(REG_CTRL, ctrl);
    afeltc_scanner_inst.sample(3);
    afeltc_scanner_inst.tick(6);
    cmp({n_up > b_up, n_lo > b_lo}, {ctrl[1], !ctrl[1]});
    cmp(o_clamp_upper, ctrl[1]);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    i_resetn <= 1'b0;
    i_clk_en <= 1'b1;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_conv_valid <= 1'b0;
    i_addr <= '0;
    i_wdata <= '0;
    i_conv_result <= '0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    t_regs();
    t_serial();
    t_line();
    t_rot();
    t_pol(32'h0A);
    t_pol(32'h08);
    t_fast();
    print_verdict();
  end
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
